/* stl_defines.svh */
`ifndef STL_DEFINES_SVH
`define STL_DEFINES_SVH
// ==========================================================
// Limit settings, percent of rated torque
`define STL_LIMIT_MAX      10'h320
`define STL_INT_LIMIT_RST  10'h320
`define STL_EXT_LIMIT_RST  10'h064
// ==========================================================
// Pin allocation field: two nibbles, value 0 means unassigned
`define STL_ALLOC_FWD_LSB  0
`define STL_ALLOC_REV_LSB  4
`define STL_ALLOC_OFF      4'h0
`endif

/* stl_pkg.sv */
// ==========================================================
// Shared types
package stl_pkg;
  typedef logic [9:0] stl_pct_t;
  typedef logic [15:0] stl_trq_t;
  typedef enum logic [1:0] {
    STL_LIM_NONE = 2'b00,
    STL_LIM_INT  = 2'b01,
    STL_LIM_EXT  = 2'b10,
    STL_LIM_CMD  = 2'b11
  } stl_src_e;
endpackage

/* stl_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Carrier between top and per-direction limit chooser
interface stl_if;
  stl_pkg::stl_pct_t int_lim;
  stl_pkg::stl_pct_t ext_lim;
  stl_pkg::stl_pct_t cmd_lim;
  logic              ext_on;
  logic              cmd_on;
  stl_pkg::stl_pct_t motor_max;
  stl_pkg::stl_pct_t result;
  modport top (output int_lim, ext_lim, cmd_lim, ext_on, cmd_on, motor_max, input result);
  modport sel (input int_lim, ext_lim, cmd_lim, ext_on, cmd_on, motor_max, output result);
endinterface
`default_nettype wire

/* stl_dir_select.sv */
`timescale 1ns/1ps
`default_nettype none
`include "stl_defines.svh"
// ==========================================================
// Combinational minimum of active sources, then motor clamp
module stl_dir_select (
  stl_if.sel s
);
  stl_pkg::stl_pct_t m1;  // Internal vs external
  stl_pkg::stl_pct_t m2;  // With command value
  always_comb begin
    // Internal is always a candidate
    m1 = s.int_lim;
    if (s.ext_on && s.ext_lim < s.int_lim) begin
      m1 = s.ext_lim;
    end
    m2 = m1;
    if (s.cmd_on && s.cmd_lim < m1) begin
      m2 = s.cmd_lim;
    end
  end
  // Motor maximum caps everything
  assign s.result = (m2 > s.motor_max) ? s.motor_max : m2;
endmodule
`default_nettype wire

/* stl_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "stl_defines.svh"
// ==========================================================
// Torque limit selector: registers settings, syncs pins,
// picks per-direction limit and clamps signed torque
module stl_top (
  // Clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  // Setting writes, percent; one strobe per setting
  input  wire logic              INT_FWD_WE_I,
  input  wire logic              INT_REV_WE_I,
  input  wire logic              EXT_FWD_WE_I,
  input  wire logic              EXT_REV_WE_I,
  input  wire logic [9:0]        LIMIT_WDATA_I,
  input  wire logic [7:0]        INPUT_PIN_ALLOCATION_I,
  // Motor capability, percent of rated
  input  wire logic [9:0]        MOTOR_MAX_I,
  // Discrete pins from host, high = contact closed
  input  wire logic              FWD_LIMIT_REQUEST_IN_I,
  input  wire logic              REV_LIMIT_REQUEST_IN_I,
  // Network command sources
  input  wire logic [9:0]        COMMAND_TORQUE_LIMIT_VALUE_I,
  input  wire logic              COMMAND_TORQUE_LIMIT_EN_I,
  input  wire logic              CMD_FWD_LIMIT_BIT_I,
  input  wire logic              CMD_REV_LIMIT_BIT_I,
  // Torque path, signed, 1 LSB = 1 percent of rated
  input  wire logic signed [15:0] TORQUE_REF_I,
  output logic signed [15:0]      TORQUE_OUT_O,
  // Status
  output logic [9:0]             FWD_LIMIT_O,
  output logic [9:0]             REV_LIMIT_O,
  output logic [9:0]             INTERNAL_FWD_TORQUE_LIMIT_O,
  output logic [9:0]             INTERNAL_REV_TORQUE_LIMIT_O,
  output logic [9:0]             EXTERNAL_FWD_TORQUE_LIMIT_O,
  output logic [9:0]             EXTERNAL_REV_TORQUE_LIMIT_O
);
  // ========================================================
  // Settings
  stl_pkg::stl_pct_t internal_fwd_torque_limit;  // Stored internal fwd
  stl_pkg::stl_pct_t internal_rev_torque_limit;  // Stored internal rev
  stl_pkg::stl_pct_t external_fwd_torque_limit;  // Stored external fwd
  stl_pkg::stl_pct_t external_rev_torque_limit;  // Stored external rev
  stl_pkg::stl_pct_t wdata_sat;                  // Write data held in range
  // Out-of-range writes saturate rather than wrap, safer for the machine
  assign wdata_sat = (LIMIT_WDATA_I > `STL_LIMIT_MAX) ? `STL_LIMIT_MAX : LIMIT_WDATA_I;
  // Each setting takes effect the cycle after its strobe
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      internal_fwd_torque_limit <= `STL_INT_LIMIT_RST;
      internal_rev_torque_limit <= `STL_INT_LIMIT_RST;
      external_fwd_torque_limit <= `STL_EXT_LIMIT_RST;
      external_rev_torque_limit <= `STL_EXT_LIMIT_RST;
    end else begin
      if (INT_FWD_WE_I) internal_fwd_torque_limit <= wdata_sat;
      if (INT_REV_WE_I) internal_rev_torque_limit <= wdata_sat;
      if (EXT_FWD_WE_I) external_fwd_torque_limit <= wdata_sat;
      if (EXT_REV_WE_I) external_rev_torque_limit <= wdata_sat;
    end
  end
  // ========================================================
  // Pin synchronisers; first stage read only by second
  logic [1:0] req_meta;  // Stage one
  logic [1:0] req_sync;  // Stage two
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      req_meta <= 2'h0;
      req_sync <= 2'h0;
    end else begin
      req_meta <= {REV_LIMIT_REQUEST_IN_I, FWD_LIMIT_REQUEST_IN_I};
      req_sync <= req_meta;
    end
  end
  // Unallocated request is ignored regardless of pin level
  logic fwd_alloc;  // Forward request has a pin
  logic rev_alloc;  // Reverse request has a pin
  assign fwd_alloc = INPUT_PIN_ALLOCATION_I[`STL_ALLOC_FWD_LSB +: 4] != `STL_ALLOC_OFF;
  assign rev_alloc = INPUT_PIN_ALLOCATION_I[`STL_ALLOC_REV_LSB +: 4] != `STL_ALLOC_OFF;
  // ========================================================
  // Per-direction selection
  // One carrier per direction keeps both choosers identical
  stl_if fwd_if ();
  stl_if rev_if ();
  assign fwd_if.int_lim   = internal_fwd_torque_limit;
  assign fwd_if.ext_lim   = external_fwd_torque_limit;
  assign fwd_if.cmd_lim   = COMMAND_TORQUE_LIMIT_VALUE_I;
  assign fwd_if.ext_on    = req_sync[0] & fwd_alloc;
  assign fwd_if.cmd_on    = COMMAND_TORQUE_LIMIT_EN_I | CMD_FWD_LIMIT_BIT_I;
  assign fwd_if.motor_max = MOTOR_MAX_I;
  assign rev_if.int_lim   = internal_rev_torque_limit;
  assign rev_if.ext_lim   = external_rev_torque_limit;
  assign rev_if.cmd_lim   = COMMAND_TORQUE_LIMIT_VALUE_I;
  assign rev_if.ext_on    = req_sync[1] & rev_alloc;
  assign rev_if.cmd_on    = COMMAND_TORQUE_LIMIT_EN_I | CMD_REV_LIMIT_BIT_I;
  assign rev_if.motor_max = MOTOR_MAX_I;
  // Bit command with no value given limits via the same value input
  stl_dir_select u_fwd (
    .s (fwd_if.sel)
  );
  stl_dir_select u_rev (
    .s (rev_if.sel)
  );
  // ========================================================
  // Output clamp, registered
  logic signed [15:0] fwd_s;  // Positive ceiling
  logic signed [15:0] rev_s;  // Negative floor
  logic signed [15:0] next_torque;
  assign fwd_s = $signed({6'h00, fwd_if.result});
  assign rev_s = -$signed({6'h00, rev_if.result});
  always_comb begin
    next_torque = TORQUE_REF_I;
    if (TORQUE_REF_I > fwd_s) begin
      next_torque = fwd_s;
    end else if (TORQUE_REF_I < rev_s) begin
      next_torque = rev_s;
    end
  end
  // Status and torque registered: one cycle latency
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      TORQUE_OUT_O <= 16'sh0000;
      FWD_LIMIT_O  <= 10'h000;
      REV_LIMIT_O  <= 10'h000;
    end else begin
      TORQUE_OUT_O <= next_torque;
      FWD_LIMIT_O  <= fwd_if.result;
      REV_LIMIT_O  <= rev_if.result;
    end
  end
  // Stored settings mirrored straight out, no added latency
  // Host can read back a saturated write at once
  assign INTERNAL_FWD_TORQUE_LIMIT_O = internal_fwd_torque_limit;
  assign INTERNAL_REV_TORQUE_LIMIT_O = internal_rev_torque_limit;
  assign EXTERNAL_FWD_TORQUE_LIMIT_O = external_fwd_torque_limit;
  assign EXTERNAL_REV_TORQUE_LIMIT_O = external_rev_torque_limit;
  // ========================================================
  // Assertions
  property p_int_bound;
    @(posedge CLK_I) disable iff (RST_I) FWD_LIMIT_O <= $past(internal_fwd_torque_limit);
  endproperty
  a_int_bound: assert property (p_int_bound) else $error("fwd above internal");
  property p_range;
    @(posedge CLK_I) disable iff (RST_I) internal_rev_torque_limit <= 10'h320;
  endproperty
  a_range: assert property (p_range) else $error("setting out of range");
  property p_motor;
    @(posedge CLK_I) disable iff (RST_I) ##1 REV_LIMIT_O <= $past(MOTOR_MAX_I);
  endproperty
  a_motor: assert property (p_motor) else $error("rev above motor max");
  property p_ext_fwd;
    @(posedge CLK_I) disable iff (RST_I)
      (fwd_if.ext_on && !fwd_if.cmd_on && external_fwd_torque_limit < internal_fwd_torque_limit
       && external_fwd_torque_limit <= MOTOR_MAX_I) |=> FWD_LIMIT_O == $past(external_fwd_torque_limit);
  endproperty
  a_ext_fwd: assert property (p_ext_fwd) else $error("fwd external not applied");
  property p_noext_fwd;
    @(posedge CLK_I) disable iff (RST_I)
      (!fwd_if.ext_on && !fwd_if.cmd_on && internal_fwd_torque_limit <= MOTOR_MAX_I)
      |=> FWD_LIMIT_O == $past(internal_fwd_torque_limit);
  endproperty
  a_noext_fwd: assert property (p_noext_fwd) else $error("fwd not internal");
  property p_ext_rev;
    @(posedge CLK_I) disable iff (RST_I)
      (rev_if.ext_on && !rev_if.cmd_on && external_rev_torque_limit < internal_rev_torque_limit
       && external_rev_torque_limit <= MOTOR_MAX_I) |=> REV_LIMIT_O == $past(external_rev_torque_limit);
  endproperty
  a_ext_rev: assert property (p_ext_rev) else $error("rev external not applied");
  property p_noext_rev;
    @(posedge CLK_I) disable iff (RST_I)
      (!rev_if.ext_on && !rev_if.cmd_on && internal_rev_torque_limit <= MOTOR_MAX_I)
      |=> REV_LIMIT_O == $past(internal_rev_torque_limit);
  endproperty
  a_noext_rev: assert property (p_noext_rev) else $error("rev not internal");
  property p_alloc;
    @(posedge CLK_I) disable iff (RST_I) !fwd_alloc |-> !fwd_if.ext_on;
  endproperty
  a_alloc: assert property (p_alloc) else $error("unallocated request used");
  property p_cmd;
    @(posedge CLK_I) disable iff (RST_I)
      fwd_if.cmd_on |=> FWD_LIMIT_O <= $past(COMMAND_TORQUE_LIMIT_VALUE_I);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command limit ignored");
  property p_clamp;
    @(posedge CLK_I) disable iff (RST_I)
      ##1 (TORQUE_OUT_O <= $signed({6'h00, FWD_LIMIT_O})) && (TORQUE_OUT_O >= -$signed({6'h00, REV_LIMIT_O}));
  endproperty
  a_clamp: assert property (p_clamp) else $error("torque outside limits");
  // ========================================================
  // Per-direction, storage and clamp checks
  // Reverse limit never above stored internal reverse
  property p_int_bound_rev;
    @(posedge CLK_I) disable iff (RST_I) REV_LIMIT_O <= $past(internal_rev_torque_limit);
  endproperty
  a_int_bound_rev: assert property (p_int_bound_rev) else $error("rev above internal");
  // Forward limit never above motor maximum
  property p_motor_fwd;
    @(posedge CLK_I) disable iff (RST_I) ##1 FWD_LIMIT_O <= $past(MOTOR_MAX_I);
  endproperty
  a_motor_fwd: assert property (p_motor_fwd) else $error("fwd above motor max");
  // Stored internal forward stays in range
  property p_range_fwd;
    @(posedge CLK_I) disable iff (RST_I) internal_fwd_torque_limit <= `STL_LIMIT_MAX;
  endproperty
  a_range_fwd: assert property (p_range_fwd) else $error("int fwd out of range");
  // Stored external forward stays in range
  property p_range_ext_fwd;
    @(posedge CLK_I) disable iff (RST_I) external_fwd_torque_limit <= `STL_LIMIT_MAX;
  endproperty
  a_range_ext_fwd: assert property (p_range_ext_fwd) else $error("ext fwd out of range");
  // Stored external reverse stays in range
  property p_range_ext_rev;
    @(posedge CLK_I) disable iff (RST_I) external_rev_torque_limit <= `STL_LIMIT_MAX;
  endproperty
  a_range_ext_rev: assert property (p_range_ext_rev) else $error("ext rev out of range");
  // A strobe stores the saturated data next cycle
  property p_wr_int_fwd;
    @(posedge CLK_I) disable iff (RST_I) INT_FWD_WE_I |=> internal_fwd_torque_limit == $past(wdata_sat);
  endproperty
  a_wr_int_fwd: assert property (p_wr_int_fwd) else $error("int fwd write lost");
  // Internal reverse write takes effect the next cycle
  property p_wr_int_rev;
    @(posedge CLK_I) disable iff (RST_I) INT_REV_WE_I |=> internal_rev_torque_limit == $past(wdata_sat);
  endproperty
  a_wr_int_rev: assert property (p_wr_int_rev) else $error("int rev write lost");
  // External forward write takes effect the next cycle
  property p_wr_ext_fwd;
    @(posedge CLK_I) disable iff (RST_I) EXT_FWD_WE_I |=> external_fwd_torque_limit == $past(wdata_sat);
  endproperty
  a_wr_ext_fwd: assert property (p_wr_ext_fwd) else $error("ext fwd write lost");
  // External reverse write takes effect the next cycle
  property p_wr_ext_rev;
    @(posedge CLK_I) disable iff (RST_I) EXT_REV_WE_I |=> external_rev_torque_limit == $past(wdata_sat);
  endproperty
  a_wr_ext_rev: assert property (p_wr_ext_rev) else $error("ext rev write lost");
  // Unallocated reverse request is ignored
  property p_alloc_rev;
    @(posedge CLK_I) disable iff (RST_I) !rev_alloc |-> !rev_if.ext_on;
  endproperty
  a_alloc_rev: assert property (p_alloc_rev) else $error("unallocated rev request used");
  // Second synchroniser stage follows the first by one cycle
  property p_sync;
    @(posedge CLK_I) disable iff (RST_I) ##1 req_sync == $past(req_meta);
  endproperty
  a_sync: assert property (p_sync) else $error("request sync skipped a stage");
  // Command value bounds reverse when active
  property p_cmd_rev;
    @(posedge CLK_I) disable iff (RST_I) rev_if.cmd_on |=> REV_LIMIT_O <= $past(COMMAND_TORQUE_LIMIT_VALUE_I);
  endproperty
  a_cmd_rev: assert property (p_cmd_rev) else $error("rev command limit ignored");
  // Forward bit alone applies the command value forward
  property p_bit_fwd;
    @(posedge CLK_I) disable iff (RST_I) CMD_FWD_LIMIT_BIT_I |=> FWD_LIMIT_O <= $past(COMMAND_TORQUE_LIMIT_VALUE_I);
  endproperty
  a_bit_fwd: assert property (p_bit_fwd) else $error("fwd command bit ignored");
  // Reverse bit alone applies the command value reverse
  property p_bit_rev;
    @(posedge CLK_I) disable iff (RST_I) CMD_REV_LIMIT_BIT_I |=> REV_LIMIT_O <= $past(COMMAND_TORQUE_LIMIT_VALUE_I);
  endproperty
  a_bit_rev: assert property (p_bit_rev) else $error("rev command bit ignored");
  // Active forward request bounds by the external setting
  property p_ext_bound_fwd;
    @(posedge CLK_I) disable iff (RST_I) fwd_if.ext_on |=> FWD_LIMIT_O <= $past(external_fwd_torque_limit);
  endproperty
  a_ext_bound_fwd: assert property (p_ext_bound_fwd) else $error("fwd above external");
  // Active reverse request bounds by the external setting
  property p_ext_bound_rev;
    @(posedge CLK_I) disable iff (RST_I) rev_if.ext_on |=> REV_LIMIT_O <= $past(external_rev_torque_limit);
  endproperty
  a_ext_bound_rev: assert property (p_ext_bound_rev) else $error("rev above external");
  // Reference inside both limits passes unchanged
  property p_pass;
    @(posedge CLK_I) disable iff (RST_I) (TORQUE_REF_I <= fwd_s && TORQUE_REF_I >= rev_s) |=> TORQUE_OUT_O == $past(TORQUE_REF_I);
  endproperty
  a_pass: assert property (p_pass) else $error("torque altered inside limits");
  // Positive excess is cut to the forward limit
  property p_pos_cap;
    @(posedge CLK_I) disable iff (RST_I) (TORQUE_REF_I > fwd_s) |=> TORQUE_OUT_O == $past(fwd_s);
  endproperty
  a_pos_cap: assert property (p_pos_cap) else $error("positive torque not capped");
  // Negative excess is cut to the reverse limit
  property p_neg_cap;
    @(posedge CLK_I) disable iff (RST_I) (TORQUE_REF_I < rev_s) |=> TORQUE_OUT_O == $past(rev_s);
  endproperty
  a_neg_cap: assert property (p_neg_cap) else $error("negative torque not capped");
  // Smallest command value wins forward
  property p_cmd_wins_fwd;
    @(posedge CLK_I) disable iff (RST_I) (fwd_if.cmd_on && fwd_if.cmd_lim <= fwd_if.int_lim && fwd_if.cmd_lim <= MOTOR_MAX_I
      && (!fwd_if.ext_on || fwd_if.cmd_lim <= fwd_if.ext_lim)) |=> FWD_LIMIT_O == $past(fwd_if.cmd_lim);
  endproperty
  a_cmd_wins_fwd: assert property (p_cmd_wins_fwd) else $error("fwd smallest not chosen");
  // Smallest command value wins reverse
  property p_cmd_wins_rev;
    @(posedge CLK_I) disable iff (RST_I) (rev_if.cmd_on && rev_if.cmd_lim <= rev_if.int_lim && rev_if.cmd_lim <= MOTOR_MAX_I
      && (!rev_if.ext_on || rev_if.cmd_lim <= rev_if.ext_lim)) |=> REV_LIMIT_O == $past(rev_if.cmd_lim);
  endproperty
  a_cmd_wins_rev: assert property (p_cmd_wins_rev) else $error("rev smallest not chosen");
  c_ext_fwd: cover property (@(posedge CLK_I) disable iff (RST_I) fwd_if.ext_on ##1 !fwd_if.ext_on);
  c_clamp_pos: cover property (@(posedge CLK_I) disable iff (RST_I) TORQUE_REF_I > fwd_s);
  c_clamp_neg: cover property (@(posedge CLK_I) disable iff (RST_I) TORQUE_REF_I < rev_s);
  c_cmd: cover property (@(posedge CLK_I) disable iff (RST_I) rev_if.cmd_on);
endmodule
`default_nettype wire

/* stl_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host controller model: drives the discrete limit contacts
module stl_host_model (
  // Clock
  input  wire logic clk_i,
  // Contact state wanted by the bench
  input  wire logic fwd_close_i,
  input  wire logic rev_close_i,
  // Contacts toward the drive, closed = high
  output var logic  fwd_pin_o = 1'b0,
  output var logic  rev_pin_o = 1'b0
);
  // Contacts move on the rising edge, through nonblocking assignments
  always @(posedge clk_i) begin
    fwd_pin_o <= fwd_close_i;
    rev_pin_o <= rev_close_i;
  end
endmodule
`default_nettype wire

/* test_servo_torque_limit_selector.sv */
`timescale 1ns/1ps
`default_nettype none
`include "stl_defines.svh"
module test_servo_torque_limit_selector;
  // ==========================================================
  // Stimulus and observed signals
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  we = 4'h0; // Int fwd, int rev, ext fwd, ext rev
  logic [9:0]  wdata = 10'h000;
  logic [7:0]  alloc = 8'h00;
  logic [9:0]  mmax = 10'h320;
  logic [9:0]  cval = 10'h000;
  logic        cen = 1'b0, cf = 1'b0, cr = 1'b0, fc = 1'b0, rc = 1'b0;
  logic signed [15:0] tref = 16'sh0000, tout;
  logic        fpin, rpin;
  logic [9:0]  flim, rlim, ifw, irv, efw, erv;
  int          err_total = 0;
  int          checks_done = 0;
  // Shadow of the four settings, as reset leaves them
  int          sv[4] = '{`STL_INT_LIMIT_RST, `STL_INT_LIMIT_RST,
                         `STL_EXT_LIMIT_RST, `STL_EXT_LIMIT_RST};
  // ==========================================================
  // Design and host model
  stl_top i_stl_top (.CLK_I(clk), .RST_I(rst), .INT_FWD_WE_I(we[0]),
    .INT_REV_WE_I(we[1]), .EXT_FWD_WE_I(we[2]), .EXT_REV_WE_I(we[3]),
    .LIMIT_WDATA_I(wdata), .INPUT_PIN_ALLOCATION_I(alloc), .MOTOR_MAX_I(mmax),
    .FWD_LIMIT_REQUEST_IN_I(fpin), .REV_LIMIT_REQUEST_IN_I(rpin),
    .COMMAND_TORQUE_LIMIT_VALUE_I(cval), .COMMAND_TORQUE_LIMIT_EN_I(cen),
    .CMD_FWD_LIMIT_BIT_I(cf), .CMD_REV_LIMIT_BIT_I(cr), .TORQUE_REF_I(tref),
    .TORQUE_OUT_O(tout), .FWD_LIMIT_O(flim), .REV_LIMIT_O(rlim),
    .INTERNAL_FWD_TORQUE_LIMIT_O(ifw), .INTERNAL_REV_TORQUE_LIMIT_O(irv),
    .EXTERNAL_FWD_TORQUE_LIMIT_O(efw), .EXTERNAL_REV_TORQUE_LIMIT_O(erv));
  stl_host_model i_stl_host_model (.clk_i(clk), .fwd_close_i(fc),
    .rev_close_i(rc), .fwd_pin_o(fpin), .rev_pin_o(rpin));
  // ==========================================================
  // Expectation helpers
  function automatic int sat(int v);
    return v > `STL_LIMIT_MAX ? `STL_LIMIT_MAX : v;
  endfunction
  // Smallest active source, then the motor ceiling
  function automatic int lim(int i, int e, bit eo, int c, bit co);
    int r;
    r = i;
    if (eo && e < r) r = e;
    if (co && c < r) r = c;
    return mmax < r ? int'(mmax) : r;
  endfunction
  task automatic chk_v(string n, logic [9:0] e, logic [9:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %0d got %0d", n, e, g);
    end
  endtask
  task automatic chk_t(string n, logic signed [15:0] e, logic signed [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %0d got %0d", n, e, g);
    end
  endtask
  // One strobed write; the shadow keeps the saturated value
  task automatic wr(int k, int v);
    @(posedge clk);
    we[k] <= 1'b1;
    wdata <= v[9:0];
    sv[k] = sat(v);
    @(posedge clk);
    we[k] <= 1'b0;
  endtask
  // Waits past the pin synchroniser, then checks every output
  task automatic check_all(string t);
    int f, r, q;
    repeat (5) @(posedge clk);
    #1;
    f = lim(sv[0], sv[2], fc && alloc[3:0] != 4'h0, cval, cen || cf);
    r = lim(sv[1], sv[3], rc && alloc[7:4] != 4'h0, cval, cen || cr);
    q = tref > f ? f : (tref < -r ? -r : int'(tref));
    chk_v("int_fwd", sv[0][9:0], ifw);
    chk_v("int_rev", sv[1][9:0], irv);
    chk_v("ext_fwd", sv[2][9:0], efw);
    chk_v("ext_rev", sv[3][9:0], erv);
    chk_v("fwd_lim", f[9:0], flim);
    chk_v("rev_lim", r[9:0], rlim);
    chk_t("torque", q[15:0], tout);
    $display("test %s done", t);
    // Return on a rising edge so the next stimulus lands on the edge
    @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // Clock, watchdog and test sequence
  initial begin
    forever #10 clk = ~clk;
  end
  // Tests need well under 2000 cycles
  initial begin
    #40000;
    err_total++;
    print_verdict();
  end
  initial begin
    void'($urandom(74));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    check_all("reset");
    // Out-of-range writes saturate, zero reverse limit stops torque
    alloc <= 8'h21;
    rc <= 1'b1;
    tref <= -16'sd300;
    wr(0, 1023);
    wr(2, 801);
    wr(3, 0);
    check_all("saturate");
    // Pin closed, external above internal: internal still rules
    fc <= 1'b1;
    tref <= 16'sd700;
    wr(0, 200);
    wr(2, 500);
    check_all("ext_above");
    // Motor ceiling below every setting but external reverse
    mmax <= 10'h032;
    check_all("motor_max");
    for (int n = 0; n < 60; n++) begin
      wr(n % 4, $urandom_range(1023));
      alloc <= n[3] ? 8'h00 : 8'($urandom);
      mmax <= 10'($urandom_range(900));
      cval <= 10'($urandom_range(900));
      {cen, cf, cr} <= 3'($urandom) & {n[2], 2'b11};
      {fc, rc} <= 2'($urandom);
      tref <= 16'($urandom_range(2000)) - 16'sd1000;
      check_all("random");
    end
    print_verdict();
  end
endmodule
`default_nettype wire
